// File: hdl/usrx_regs.svh
`ifndef USRX_REGS_SVH
`define USRX_REGS_SVH
// byte offsets on the bus
`define USRX_OFS_RX_STATUS 8'h00
`define USRX_OFS_TX_STATUS 8'h04
`define USRX_OFS_BAUD      8'h08
`define USRX_OFS_TX_DATA   8'h0c
`define USRX_OFS_RX_DATA   8'h10
`define USRX_OFS_DIV_LO    8'h14
`define USRX_OFS_DIV_HI    8'h18
`define USRX_OFS_FLAGS     8'h1c
// receive_status_control fields
`define USRX_B_PORT_EN   7
`define USRX_B_NINE_RX   6
`define USRX_B_SINGLE_RX 5
`define USRX_B_CONT_RX   4
`define USRX_B_ADDR_DET  3
`define USRX_B_FRAME_ERR 2
`define USRX_B_OVERRUN   1
`define USRX_B_NINTH_RX  0
// transmit_status_control fields
`define USRX_B_CLK_SRC   7
`define USRX_B_NINE_TX   6
`define USRX_B_TX_EN     5
`define USRX_B_SYNC_MODE 4
`define USRX_B_SEND_BRK  3
`define USRX_B_HIGH_SPD  2
`define USRX_B_TX_EMPTY  1
`define USRX_B_NINTH_TX  0
// baud_control fields
`define USRX_B_RX_IDLE   6
`define USRX_B_CLK_INV   4
`define USRX_B_WIDE_DIV  3
// flag and enable register fields
`define USRX_B_RX_FLAG   0
`define USRX_B_TX_FLAG   1
`define USRX_B_RX_IE     2
`define USRX_B_TX_IE     3
`define USRX_B_PERIPH_IE 4
`define USRX_B_GLOBAL_IE 5
`define USRX_RST_BYTE    8'h00
// divisor ticks per bit, minus one
`define USRX_OVS_X64     6'h3f
`define USRX_OVS_X16     6'h0f
`define USRX_OVS_X4      6'h03
`endif

// File: hdl/usrx_pkg.sv
package usrx_pkg;
  typedef enum logic [1:0] {
    ARX_IDLE  = 2'b00,
    ARX_START = 2'b01,
    ARX_DATA  = 2'b11,
    ARX_STOP  = 2'b10
  } usrx_arx_t;

  typedef struct packed {
    usrx_arx_t   st;
    logic [15:0] div;
    logic [5:0]  ph;
    logic [3:0]  nb;
    logic [8:0]  sh;
    logic        done, frm_err;
    logic [8:0]  data;
  } usrx_arx_state_t;

  typedef struct packed {
    logic            ack;
    logic [7:0]      rdat;
    logic            pen, nine_rx, srx_en, crx_en, addr_det, ovr;
    logic            csel, nine_tx, tx_en, sync_mode, brk, hspd, ninth_tx;
    logic            clk_inv, wide_div, rx_ie, tx_ie, per_ie, glob_ie;
    logic [7:0]      div_lo, div_hi;
    logic [8:0]      tx_buf, tx_sh, rx_sh;
    logic            tx_full, tx_busy;
    logic [3:0]      tx_cnt, rx_cnt;
    logic [1:0][9:0] fifo;
    logic            wp, rp;
    logic [1:0]      cnt;
    logic            clk_s1, clk_s2, clk_s3, dat_s1, dat_s2;
  } usrx_state_t;
endpackage

// File: hdl/usrx_rx_if.sv
`timescale 1ns/1ps
`default_nettype none
interface usrx_rx_if;
  logic        en;
  logic        nine;
  logic [1:0]  rate_sel;
  logic [15:0] divisor;
  logic        line;
  logic        done;
  logic        frm_err;
  logic [8:0]  data;
  logic        idle;
  modport core (output en, nine, rate_sel, divisor, line, input done, frm_err, data, idle);
  modport engine (input en, nine, rate_sel, divisor, line, output done, frm_err, data, idle);
endinterface
`default_nettype wire

// File: hdl/usrx_async_rx.sv
`timescale 1ns/1ps
`default_nettype none
module usrx_async_rx (
  input wire logic clk,
  input wire logic rst,
  usrx_rx_if.engine rx
);
  `include "usrx_regs.svh"
  usrx_pkg::usrx_arx_state_t q;
  usrx_pkg::usrx_arx_state_t next_q;
  logic [5:0] len;
  logic       tick;
  logic [3:0] last;

  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    if (rx.rate_sel == 2'b00) len = `USRX_OVS_X64;
    else if (rx.rate_sel == 2'b11) len = `USRX_OVS_X4;
    else len = `USRX_OVS_X16;
    tick = (q.div == rx.divisor);
    last = rx.nine ? 4'h8 : 4'h7;
    if (!rx.en) begin
      next_q.st = usrx_pkg::ARX_IDLE;
      next_q.div = 16'h0;
    end else begin
      next_q.div = tick ? 16'h0 : q.div + 16'h1;
      unique case (q.st)
        usrx_pkg::ARX_IDLE: if (!rx.line) begin
          next_q.st = usrx_pkg::ARX_START;
          next_q.ph = 6'h0;
          next_q.div = 16'h0;
        end
        usrx_pkg::ARX_START: if (tick) begin
          // a start edge shorter than half a bit is a glitch
          if (q.ph == (len >> 1)) begin
            next_q.st = rx.line ? usrx_pkg::ARX_IDLE : usrx_pkg::ARX_DATA;
            next_q.ph = 6'h0;
            next_q.nb = 4'h0;
          end else next_q.ph = q.ph + 6'h1;
        end
        usrx_pkg::ARX_DATA: if (tick) begin
          next_q.ph = (q.ph == len) ? 6'h0 : q.ph + 6'h1;
          if (q.ph == len) begin
            next_q.sh = {rx.line, q.sh[8:1]};
            next_q.nb = q.nb + 4'h1;
            if (q.nb == last) next_q.st = usrx_pkg::ARX_STOP;
          end
        end
        usrx_pkg::ARX_STOP: if (tick) begin
          next_q.ph = (q.ph == len) ? 6'h0 : q.ph + 6'h1;
          if (q.ph == len) begin
            next_q.done = 1'b1;
            next_q.frm_err = !rx.line;
            next_q.data = rx.nine ? q.sh : {1'b0, q.sh[8:1]};
            next_q.st = usrx_pkg::ARX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) q <= '0;
    else q <= next_q;
  end

  assign rx.done = q.done;
  assign rx.frm_err = q.frm_err;
  assign rx.data = q.data;
  assign rx.idle = (q.st == usrx_pkg::ARX_IDLE);
endmodule // usrx_async_rx
`default_nettype wire

// File: hdl/usrx_port.sv
`timescale 1ns/1ps
`default_nettype none
module usrx_port (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_wr,
  output logic      [31:0] wb_dat_rd,
  output logic             wb_ack,
  input  wire logic        sync_clock_pin,
  input  wire logic        sync_data_pin_level,
  output logic             sync_data_pin_drive,
  output logic             sync_data_pin_oe_n,
  output logic             wake_request,
  output logic             interrupt_request
);
  `include "usrx_regs.svh"
  usrx_pkg::usrx_state_t q;
  usrx_pkg::usrx_state_t next_q;
  usrx_rx_if arx ();

  logic       wr, rd_pop, req;
  logic       clk_now, clk_was, fall;
  logic       stx_mode, srx_mode;
  logic       dlv, dlv_fe, keep, push;
  logic [8:0] dlv_d, rx_word;
  logic [3:0] rlast, tlast;
  logic [9:0] head;
  logic       rx_flag, tx_flag;
  logic [7:0] rd_val;

  ////////////////////////////////////////////////////////////////////
  // async receive engine
  assign arx.en = q.pen & ~q.sync_mode & q.crx_en & ~q.ovr;
  assign arx.nine = q.nine_rx;
  assign arx.rate_sel = {q.wide_div, q.hspd};
  assign arx.divisor = {q.div_hi, q.div_lo};
  assign arx.line = q.dat_s2;

  usrx_async_rx u_arx (
    .clk (clk),
    .rst (rst),
    .rx  (arx)
  );

  ////////////////////////////////////////////////////////////////////
  // mode decode and flags
  assign clk_now = q.clk_s2 ^ q.clk_inv;
  assign clk_was = q.clk_s3 ^ q.clk_inv;
  assign fall = clk_was & ~clk_now;
  // slave only: clock source must be clear, nothing drives the clock
  assign stx_mode = q.pen & q.sync_mode & ~q.csel & ~q.srx_en & ~q.crx_en & q.tx_en;
  // either receive enable picks receive; behaves as continuous
  assign srx_mode = q.pen & q.sync_mode & ~q.csel & (q.srx_en | q.crx_en);
  assign rlast = q.nine_rx ? 4'h8 : 4'h7;
  assign tlast = q.nine_tx ? 4'h8 : 4'h7;
  assign head = q.fifo[q.rp];
  assign rx_flag = (q.cnt != 2'h0);
  assign tx_flag = ~q.tx_full;
  assign req = wb_cyc & wb_stb & ~q.ack;
  assign wr = q.ack & wb_we & wb_sel[0];
  assign rd_pop = q.ack & ~wb_we & (wb_adr == `USRX_OFS_RX_DATA) & rx_flag;

  always_comb begin
    rx_word = q.rx_sh;
    rx_word[q.rx_cnt] = q.dat_s2;
    if (!q.nine_rx) rx_word[8] = 1'b0;
    dlv = arx.done | (srx_mode & ~q.ovr & fall & q.rx_cnt == rlast);
    dlv_d = arx.done ? arx.data : rx_word;
    dlv_fe = arx.done & arx.frm_err;
    // address mode drops characters with ninth bit clear
    keep = ~(q.nine_rx & q.addr_det & ~q.sync_mode & ~dlv_d[8]);
    push = dlv & keep;
  end

  ////////////////////////////////////////////////////////////////////
  // register read mux
  always_comb begin
    rd_val = 8'h00;
    unique case (wb_adr)
      `USRX_OFS_RX_STATUS: begin
        rd_val[`USRX_B_PORT_EN] = q.pen;
        rd_val[`USRX_B_NINE_RX] = q.nine_rx;
        rd_val[`USRX_B_SINGLE_RX] = q.srx_en;
        rd_val[`USRX_B_CONT_RX] = q.crx_en;
        rd_val[`USRX_B_ADDR_DET] = q.addr_det;
        rd_val[`USRX_B_FRAME_ERR] = head[9] & rx_flag;
        rd_val[`USRX_B_OVERRUN] = q.ovr;
        rd_val[`USRX_B_NINTH_RX] = head[8] & rx_flag;
      end
      `USRX_OFS_TX_STATUS: begin
        rd_val[`USRX_B_CLK_SRC] = q.csel;
        rd_val[`USRX_B_NINE_TX] = q.nine_tx;
        rd_val[`USRX_B_TX_EN] = q.tx_en;
        rd_val[`USRX_B_SYNC_MODE] = q.sync_mode;
        rd_val[`USRX_B_SEND_BRK] = q.brk;
        rd_val[`USRX_B_HIGH_SPD] = q.hspd;
        rd_val[`USRX_B_TX_EMPTY] = ~q.tx_busy;
        rd_val[`USRX_B_NINTH_TX] = q.ninth_tx;
      end
      `USRX_OFS_BAUD: begin
        rd_val[`USRX_B_RX_IDLE] = arx.idle & (q.rx_cnt == 4'h0);
        rd_val[`USRX_B_CLK_INV] = q.clk_inv;
        rd_val[`USRX_B_WIDE_DIV] = q.wide_div;
      end
      `USRX_OFS_RX_DATA: rd_val = rx_flag ? head[7:0] : 8'h00;
      `USRX_OFS_DIV_LO: rd_val = q.div_lo;
      `USRX_OFS_DIV_HI: rd_val = q.div_hi;
      `USRX_OFS_FLAGS: begin
        rd_val[`USRX_B_RX_FLAG] = rx_flag;
        rd_val[`USRX_B_TX_FLAG] = tx_flag;
        rd_val[`USRX_B_RX_IE] = q.rx_ie;
        rd_val[`USRX_B_TX_IE] = q.tx_ie;
        rd_val[`USRX_B_PERIPH_IE] = q.per_ie;
        rd_val[`USRX_B_GLOBAL_IE] = q.glob_ie;
      end
      default: rd_val = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_q = q;
    next_q.clk_s1 = sync_clock_pin;
    next_q.clk_s2 = q.clk_s1;
    next_q.clk_s3 = q.clk_s2;
    next_q.dat_s1 = sync_data_pin_level;
    next_q.dat_s2 = q.dat_s1;
    next_q.ack = req;
    if (req) next_q.rdat = rd_val;

    // synchronous slave transmit
    if (!stx_mode) begin
      next_q.tx_busy = 1'b0;
      next_q.tx_cnt = 4'h0;
    end else if (q.tx_busy) begin
      if (fall) begin
        next_q.tx_sh = {1'b0, q.tx_sh[8:1]};
        next_q.tx_cnt = q.tx_cnt + 4'h1;
        if (q.tx_cnt == tlast) next_q.tx_busy = 1'b0;
      end
    end else if (q.tx_full) begin
      // apart from port off, the flag rises only as the buffered word moves to the shifter
      next_q.tx_sh = q.tx_buf;
      next_q.tx_busy = 1'b1;
      next_q.tx_full = 1'b0;
      next_q.tx_cnt = 4'h0;
    end

    // synchronous slave receive, sampled on the falling edge with clk_inv clear, the rising edge with it set
    if (!srx_mode || q.ovr) next_q.rx_cnt = 4'h0;
    else if (fall) begin
      next_q.rx_sh = rx_word;
      next_q.rx_cnt = (q.rx_cnt == rlast) ? 4'h0 : q.rx_cnt + 4'h1;
    end

    // two-entry receive buffer
    // slave receive counts as continuous, so it clears only with the port off or with crx_en and slave receive mode both off
    if (!q.crx_en && !srx_mode) next_q.ovr = 1'b0;
    next_q.cnt = q.cnt - {1'b0, rd_pop};
    if (rd_pop) next_q.rp = ~q.rp;
    if (push) begin
      if (q.ovr) begin
        next_q.ovr = 1'b1;
      end else if (q.cnt == 2'h2 && !rd_pop) begin
        next_q.ovr = 1'b1;
      end else begin
        next_q.fifo[q.wp] = {dlv_fe, dlv_d};
        next_q.wp = ~q.wp;
        next_q.cnt = q.cnt + 2'h1 - {1'b0, rd_pop};
      end
    end

    // register writes take effect at the acknowledging edge
    if (wr) begin
      unique case (wb_adr)
        `USRX_OFS_RX_STATUS: begin
          next_q.pen = wb_dat_wr[`USRX_B_PORT_EN];
          next_q.nine_rx = wb_dat_wr[`USRX_B_NINE_RX];
          next_q.srx_en = wb_dat_wr[`USRX_B_SINGLE_RX];
          next_q.crx_en = wb_dat_wr[`USRX_B_CONT_RX];
          next_q.addr_det = wb_dat_wr[`USRX_B_ADDR_DET];
        end
        `USRX_OFS_TX_STATUS: begin
          next_q.csel = wb_dat_wr[`USRX_B_CLK_SRC];
          next_q.nine_tx = wb_dat_wr[`USRX_B_NINE_TX];
          next_q.tx_en = wb_dat_wr[`USRX_B_TX_EN];
          next_q.sync_mode = wb_dat_wr[`USRX_B_SYNC_MODE];
          next_q.brk = wb_dat_wr[`USRX_B_SEND_BRK];
          next_q.hspd = wb_dat_wr[`USRX_B_HIGH_SPD];
          next_q.ninth_tx = wb_dat_wr[`USRX_B_NINTH_TX];
        end
        `USRX_OFS_BAUD: begin
          next_q.clk_inv = wb_dat_wr[`USRX_B_CLK_INV];
          next_q.wide_div = wb_dat_wr[`USRX_B_WIDE_DIV];
        end
        `USRX_OFS_TX_DATA: begin
          // ninth bit is taken as it stands at the data write
          next_q.tx_buf = {q.ninth_tx & q.nine_tx, wb_dat_wr[7:0]};
          next_q.tx_full = 1'b1;
        end
        `USRX_OFS_DIV_LO: next_q.div_lo = wb_dat_wr[7:0];
        `USRX_OFS_DIV_HI: next_q.div_hi = wb_dat_wr[7:0];
        `USRX_OFS_FLAGS: begin
          next_q.rx_ie = wb_dat_wr[`USRX_B_RX_IE];
          next_q.tx_ie = wb_dat_wr[`USRX_B_TX_IE];
          next_q.per_ie = wb_dat_wr[`USRX_B_PERIPH_IE];
          next_q.glob_ie = wb_dat_wr[`USRX_B_GLOBAL_IE];
        end
        default: next_q.ack = next_q.ack;
      endcase
    end

    // port off resets all transfer state but keeps configuration
    if (!q.pen) begin
      next_q.cnt = 2'h0;
      next_q.wp = 1'b0;
      next_q.rp = 1'b0;
      next_q.ovr = 1'b0;
      next_q.tx_full = 1'b0;
      next_q.tx_busy = 1'b0;
      next_q.rx_cnt = 4'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) q <= '0;
    else q <= next_q;
  end

  ////////////////////////////////////////////////////////////////////
  // outputs
  assign wb_dat_rd = {24'h000000, q.rdat};
  assign wb_ack = q.ack;
  assign sync_data_pin_drive = q.tx_sh[0];
  assign sync_data_pin_oe_n = ~(stx_mode & q.tx_busy);
  // sleep has no effect here: the slave runs from the master's clock
  assign wake_request = q.per_ie & ((q.rx_ie & rx_flag) | (q.tx_ie & tx_flag));
  assign interrupt_request = wake_request & q.glob_ie;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_last_tx_fall;
    stx_mode && q.tx_busy && fall && q.tx_cnt == tlast && q.tx_full;
  endsequence
  sequence s_reload;
    !q.tx_busy ##1 q.tx_busy && !q.tx_full;
  endsequence

  chk_port_off_clears: assert property (!q.pen |=> q.cnt == 2'h0 && !q.tx_busy)
    else $error("port off left transfer state");
  chk_push_sets_flag: assert property (push && !q.ovr && q.cnt == 2'h0 && q.pen
    |=> rx_flag && $past(dlv_d) == head[8:0])
    else $error("received character not flagged");
  chk_overrun_holds: assert property (q.ovr && q.crx_en && q.pen |=> q.ovr)
    else $error("overrun dropped while continuous receive set");
  chk_overrun_clear: assert property (!q.crx_en && !srx_mode && !push |=> !q.ovr)
    else $error("overrun not cleared");
  chk_addr_discard: assert property (dlv && !keep && !rd_pop && q.pen |=> $stable(q.cnt))
    else $error("address mode kept a data character");
  chk_addr_ninth: assert property (q.addr_det && q.nine_rx && !q.sync_mode && push
    && !q.ovr && q.cnt == 2'h0 && q.pen |=> head[8])
    else $error("address character without ninth bit");
  chk_tx_reload: assert property (s_last_tx_fall |=> s_reload)
    else $error("buffered word not reloaded");
  chk_tx_flag_held: assert property (stx_mode && q.tx_busy && q.tx_full
    && !fall |=> !tx_flag)
    else $error("transmit flag set while word buffered");
  chk_tx_write: assert property (wr && wb_adr == `USRX_OFS_TX_DATA && q.pen
    |=> q.tx_full && q.tx_buf[7:0] == $past(wb_dat_wr[7:0]))
    else $error("transmit write not buffered");
  chk_no_drive: assert property (!stx_mode |-> sync_data_pin_oe_n ##1 1'b1)
    else $error("data pin driven outside slave transmit");
endmodule // usrx_port
`default_nettype wire

// File: tb/usrx_link_partner.sv
`timescale 1ns/1ps
`default_nettype none
module usrx_link_partner #(
  parameter realtime BIT_NS  = 128.0,
  parameter realtime HALF_NS = 62.5
) (
  output logic     link_clk,
  output logic     link_dat,
  input wire logic dev_drive,
  input wire logic dev_oe_n
);
  initial begin
    link_clk = 1'b1; // shift clock rests high between frames
    link_dat = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  // remote sender: start low, lsb first, stop high, then one spare bit
  task automatic send_async(input logic [8:0] v, input int nbits);
    link_dat = 1'b0;
    #BIT_NS;
    for (int i = 0; i < nbits; i++) begin
      link_dat = v[i];
      #BIT_NS;
    end
    link_dat = 1'b1;
    #(2 * BIT_NS);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // external master: data set on the rise, device bit taken at the fall
  task automatic sync_xfer(input logic [8:0] v, input int nbits, output logic [8:0] got);
    got = 9'h000;
    for (int i = 0; i < nbits; i++) begin
      link_dat = v[i];
      #HALF_NS;
      link_clk = 1'b0;
      got[i]   = dev_oe_n ? 1'bx : dev_drive;
      #HALF_NS;
      link_clk = 1'b1;
    end
    // released line must not keep showing the last bit
    link_dat = ~link_dat;
    #HALF_NS;
  endtask
endmodule // usrx_link_partner
`default_nettype wire

// File: tb/usrx_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "usrx_regs.svh"
module usrx_port_tb_top;
  logic        clk, rst, wb_cyc, wb_stb, wb_we, wb_ack;
  logic        p_clk, p_dat, dev_drive, dev_oe_n, wake, irq;
  logic [7:0]  wb_adr, q;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat_wr, wb_dat_rd;
  logic [8:0]  got;
  int          fails, n_checks;
  // both pins reach the port as plain digital levels
  wire logic   pin_level = dev_oe_n ? p_dat : dev_drive;

  usrx_port u_usrx_port (
    .clk(clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_wr(wb_dat_wr), .wb_dat_rd(wb_dat_rd),
    .wb_ack(wb_ack), .sync_clock_pin(p_clk), .sync_data_pin_level(pin_level),
    .sync_data_pin_drive(dev_drive), .sync_data_pin_oe_n(dev_oe_n),
    .wake_request(wake), .interrupt_request(irq)
  );
  usrx_link_partner u_usrx_link_partner (
    .link_clk(p_clk), .link_dat(p_dat), .dev_drive(dev_drive), .dev_oe_n(dev_oe_n)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // one classic cycle; request held until ack is seen at a rising edge
  task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] s = 4'hf);
    int n;
    @(posedge clk);
    wb_cyc    <= 1'b1;
    wb_stb    <= 1'b1;
    wb_we     <= we;
    wb_adr    <= a;
    wb_sel    <= s;
    wb_dat_wr <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (wb_ack !== 1'b1) begin
      fails++;
      $display("ERROR %0t: bus timeout", $time);
      final_report();
    end
    q = wb_dat_rd[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk8(q, e);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat_wr = 32'h00000000;
    fails = 0;
    n_checks = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(`USRX_OFS_RX_STATUS, 8'h00);
    rd(`USRX_OFS_FLAGS, 8'h02);
    rd(8'h20, 8'h00);
    xfer(1'b1, `USRX_OFS_DIV_LO, 8'h03, 4'he);
    rd(`USRX_OFS_DIV_LO, 8'h00);
    // 16 clocks per bit: divisor 3, wide and high speed set
    wr(`USRX_OFS_DIV_LO, 8'h03);
    wr(`USRX_OFS_BAUD, 8'h08);
    wr(`USRX_OFS_TX_STATUS, 8'h04);
    rd(`USRX_OFS_DIV_LO, 8'h03);
    wr(`USRX_OFS_RX_STATUS, 8'h80);
    u_usrx_link_partner.send_async(9'h05a, 8);
    rd(`USRX_OFS_FLAGS, 8'h02);
    wr(`USRX_OFS_FLAGS, 8'h14);
    wr(`USRX_OFS_RX_STATUS, 8'h90);
    u_usrx_link_partner.send_async(9'h0a5, 8);
    chk8({7'h00, wake}, 8'h01);
    chk8({7'h00, irq}, 8'h00);
    rd(`USRX_OFS_FLAGS, 8'h17);
    rd(`USRX_OFS_RX_STATUS, 8'h90);
    rd(`USRX_OFS_RX_DATA, 8'ha5);
    rd(`USRX_OFS_FLAGS, 8'h16);
    // address mode: ninth-clear character must vanish
    wr(`USRX_OFS_RX_STATUS, 8'hd8);
    u_usrx_link_partner.send_async(9'h011, 9);
    u_usrx_link_partner.send_async(9'h142, 9);
    rd(`USRX_OFS_RX_STATUS, 8'hd9);
    rd(`USRX_OFS_RX_DATA, 8'h42);
    rd(`USRX_OFS_FLAGS, 8'h16);
    wr(`USRX_OFS_RX_STATUS, 8'hd0);
    u_usrx_link_partner.send_async(9'h077, 9);
    rd(`USRX_OFS_RX_STATUS, 8'hd0);
    rd(`USRX_OFS_RX_DATA, 8'h77);
    // third character overruns a two-deep buffer
    wr(`USRX_OFS_RX_STATUS, 8'h90);
    u_usrx_link_partner.send_async(9'h001, 8);
    u_usrx_link_partner.send_async(9'h002, 8);
    u_usrx_link_partner.send_async(9'h003, 8);
    rd(`USRX_OFS_RX_STATUS, 8'h92);
    rd(`USRX_OFS_RX_DATA, 8'h01);
    wr(`USRX_OFS_RX_STATUS, 8'h80);
    rd(`USRX_OFS_RX_STATUS, 8'h80);
    rd(`USRX_OFS_RX_DATA, 8'h02);
    rd(`USRX_OFS_FLAGS, 8'h16);
    // slave receive with only the single enable set
    wr(`USRX_OFS_TX_STATUS, 8'h10);
    wr(`USRX_OFS_RX_STATUS, 8'ha0);
    u_usrx_link_partner.sync_xfer(9'h096, 8, got);
    rd(`USRX_OFS_RX_STATUS, 8'ha0);
    rd(`USRX_OFS_FLAGS, 8'h17);
    chk8({7'h00, wake}, 8'h01);
    rd(`USRX_OFS_RX_DATA, 8'h96);
    repeat (3) u_usrx_link_partner.sync_xfer(9'h0c9, 8, got);
    rd(`USRX_OFS_RX_STATUS, 8'ha2);
    wr(`USRX_OFS_RX_STATUS, 8'h00);
    rd(`USRX_OFS_RX_STATUS, 8'h00);
    // slave transmit: second word waits, flag rises at its reload
    wr(`USRX_OFS_FLAGS, 8'h18);
    wr(`USRX_OFS_RX_STATUS, 8'h80);
    wr(`USRX_OFS_TX_STATUS, 8'h30);
    wr(`USRX_OFS_TX_DATA, 8'hc3);
    wr(`USRX_OFS_TX_DATA, 8'h5e);
    rd(`USRX_OFS_FLAGS, 8'h18);
    chk8({7'h00, dev_oe_n}, 8'h00);
    chk8({7'h00, wake}, 8'h00);
    u_usrx_link_partner.sync_xfer(9'h000, 8, got);
    chk8(got[7:0], 8'hc3);
    rd(`USRX_OFS_FLAGS, 8'h1a);
    chk8({7'h00, wake}, 8'h01);
    chk8({7'h00, irq}, 8'h00);
    wr(`USRX_OFS_FLAGS, 8'h38);
    rd(`USRX_OFS_FLAGS, 8'h3a);
    chk8({7'h00, irq}, 8'h01);
    u_usrx_link_partner.sync_xfer(9'h000, 8, got);
    chk8(got[7:0], 8'h5e);
    final_report();
  end
endmodule // usrx_port_tb_top
`default_nettype wire
